// >>> src/irq_prio_ctrl.sv
// Purpose: Per-source priority registers and interrupt status for the CPU.
// Assumes: Flags and enables come from logic on the same clock; the CPU drives its level and ack.
// Notes: Register file sits on APB; unmapped addresses read zero and answer with PSLVERR.
`timescale 1ns/1ns
module irq_prio_ctrl
    import irq_prio_pkg::*;
#(
    parameter int VEC_W = 7,
    parameter logic [6:0] VEC_OFFSET = 7'h00
)
(
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic [NUM_SRC-1:0] IRQ_FLAG_IN,
    input wire logic [NUM_SRC-1:0] IRQ_ENABLE_IN,
    input wire logic [3:0] CPU_LEVEL_IN,
    input wire logic TRAP_REQ_IN,
    input wire logic [3:0] TRAP_LEVEL_IN,
    input wire logic [6:0] TRAP_VEC_IN,
    input wire logic CPU_ACK_IN,
    output logic IRQ_REQ_OUT,
    output logic [6:0] IRQ_VEC_OUT,
    output logic [3:0] IRQ_LEVEL_OUT
);
    // Elaboration checks: the status vector field is fixed at seven bits
    if (VEC_W != 7)
    begin : gen_bad_vec_w
        $error("VEC_W must be 7");
    end
    // Every source vector must fit the seven-bit map without wrapping
    if (int'(VEC_OFFSET) + NUM_SRC > 128)
    begin : gen_bad_offset
        $error("VEC_OFFSET leaves no room for every source");
    end

    // Priority field per source; register binding is in the decode below
    logic [2:0] prio_q [NUM_SRC];
    logic [2:0] prio_d [NUM_SRC];
    logic hold_q, hold_d;
    logic [6:0] vec_q, vec_d;
    logic [3:0] level_q, level_d;
    logic req_q, req_d;
    logic [31:0] rdata_q, rdata_d;
    logic ready_q, ready_d;
    logic err_q, err_d;

    logic [4:0] idx;
    logic wr_lo, wr_hi, access, setup;
    logic [15:0] wsel;
    logic [3:0] best_lvl;
    logic [6:0] best_vec;
    logic best_any;
    logic [15:0] rd_word;
    logic mapped;
    logic addr_ok;
    logic [NUM_SRC-1:0] eligible;

    assign idx = PADDR_IN[6:2];
    assign setup = PSEL_IN && !PENABLE_IN;
    assign access = PSEL_IN && PENABLE_IN && ready_q;
    // Bit 7 set would alias the low map, so such addresses are refused like unaligned ones
    assign addr_ok = (PADDR_IN[1:0] == 2'h0) && !PADDR_IN[7];
    assign wr_lo = access && PWRITE_IN && PSTRB_IN[0] && addr_ok;
    assign wr_hi = access && PWRITE_IN && PSTRB_IN[1] && addr_ok;
    assign wsel = PWDATA_IN[15:0];

    // A zero field masks the source whatever its flag and enable say
    for (genvar g = 0; g < NUM_SRC; g++)
    begin : gen_eligible
        assign eligible[g] = IRQ_FLAG_IN[g] && IRQ_ENABLE_IN[g] && (prio_q[g] != 3'h0);
    end

    // Priority arbitration; a disabled field never wins
    always_comb
    begin
        best_lvl = 4'h0;
        best_vec = 7'h00;
        best_any = 1'b0;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            // Strict compare: on a tie the lower source number keeps the win
            if (eligible[i] && {1'b0, prio_q[i]} > best_lvl)
            begin
                best_lvl = {1'b0, prio_q[i]};
                best_vec = VEC_OFFSET + 7'(i);
                best_any = 1'b1;
            end
        end
        if (TRAP_REQ_IN && TRAP_LEVEL_IN > USER_MAX_LEVEL && TRAP_LEVEL_IN > best_lvl)
        begin
            best_lvl = TRAP_LEVEL_IN;
            best_vec = TRAP_VEC_IN;
            best_any = 1'b1;
        end
    end

    // Field layout per register
    always_comb
    begin
        mapped = 1'b1;
        rd_word = 16'h0000;
        case (idx)
            IDX_PRIO_6:
            begin
                rd_word[POS_HIGH +: 3] = prio_q[SRC_TIMER_FOUR];
                rd_word[POS_LOW +: 3] = prio_q[SRC_CAPCMP_THREE];
            end
            IDX_PRIO_7:
            begin
                rd_word[POS_HIGH +: 3] = prio_q[SRC_SERIAL_TWO_TX];
                rd_word[POS_MID +: 3] = prio_q[SRC_SERIAL_TWO_RX];
                rd_word[POS_LOW +: 3] = prio_q[SRC_EXT_IRQ_TWO];
            end
            IDX_PRIO_9: rd_word[POS_LOW +: 3] = prio_q[SRC_TIMER_THREE_GATE];
            IDX_PRIO_12:
            begin
                rd_word[POS_MID +: 3] = prio_q[SRC_SYNC_TWO_COLLISION];
                rd_word[POS_LOW +: 3] = prio_q[SRC_SYNC_TWO_EVENT];
            end
            IDX_PRIO_16:
            begin
                rd_word[POS_MID +: 3] = prio_q[SRC_SERIAL_TWO_ERR];
                rd_word[POS_LOW +: 3] = prio_q[SRC_SERIAL_ONE_ERR];
            end
            IDX_PRIO_18: rd_word[POS_BOTTOM +: 3] = prio_q[SRC_VOLTAGE_DETECT];
            IDX_PRIO_20: rd_word[POS_BOTTOM +: 3] = prio_q[SRC_LOW_POWER_WAKE];
            IDX_STATUS:
            begin
                rd_word[STAT_REQ_BIT] = req_q;
                rd_word[STAT_HOLD_BIT] = hold_q;
                rd_word[STAT_LEVEL_POS +: 4] = level_q;
                rd_word[6:0] = vec_q;
            end
            default: mapped = 1'b0;
        endcase
    end

    // Register writes: only implemented bits are stored
    always_comb
    begin
        for (int i = 0; i < NUM_SRC; i++)
        begin
            prio_d[i] = prio_q[i];
        end
        hold_d = hold_q;
        if (wr_hi)
        begin
            case (idx)
                IDX_PRIO_6: prio_d[SRC_TIMER_FOUR] = wsel[POS_HIGH +: 3];
                IDX_PRIO_7:
                begin
                    prio_d[SRC_SERIAL_TWO_TX] = wsel[POS_HIGH +: 3];
                    prio_d[SRC_SERIAL_TWO_RX] = wsel[POS_MID +: 3];
                end
                IDX_PRIO_12: prio_d[SRC_SYNC_TWO_COLLISION] = wsel[POS_MID +: 3];
                IDX_PRIO_16: prio_d[SRC_SERIAL_TWO_ERR] = wsel[POS_MID +: 3];
                IDX_STATUS: hold_d = wsel[STAT_HOLD_BIT];
                default: hold_d = hold_q;
            endcase
        end
        if (wr_lo)
        begin
            case (idx)
                IDX_PRIO_6: prio_d[SRC_CAPCMP_THREE] = wsel[POS_LOW +: 3];
                IDX_PRIO_7: prio_d[SRC_EXT_IRQ_TWO] = wsel[POS_LOW +: 3];
                IDX_PRIO_9: prio_d[SRC_TIMER_THREE_GATE] = wsel[POS_LOW +: 3];
                IDX_PRIO_12: prio_d[SRC_SYNC_TWO_EVENT] = wsel[POS_LOW +: 3];
                IDX_PRIO_16: prio_d[SRC_SERIAL_ONE_ERR] = wsel[POS_LOW +: 3];
                IDX_PRIO_18: prio_d[SRC_VOLTAGE_DETECT] = wsel[POS_BOTTOM +: 3];
                IDX_PRIO_20: prio_d[SRC_LOW_POWER_WAKE] = wsel[POS_BOTTOM +: 3];
                default:
                begin
                end
            endcase
        end
    end

    // Status register contents: request, level and vector
    always_comb
    begin
        // Pending but blocked by the CPU level
        req_d = best_any && (best_lvl <= CPU_LEVEL_IN);
        level_d = level_q;
        vec_d = vec_q;
        if (hold_q)
        begin
            vec_d = best_any ? best_vec - VEC_BASE : vec_q;
        end
        if (CPU_ACK_IN && best_any && best_lvl > CPU_LEVEL_IN)
        begin
            level_d = best_lvl;
            if (!hold_q)
            begin
                vec_d = best_vec - VEC_BASE;
            end
        end
    end

    // APB: no wait state; ready and the read word are registered in the setup cycle
    always_comb
    begin
        ready_d = setup;
        rdata_d = rdata_q;
        err_d = 1'b0;
        if (setup)
        begin
            // Refused accesses read zero so software never sees an aliased word
            rdata_d = (PWRITE_IN || !addr_ok) ? 32'h0000_0000 : {16'h0000, rd_word};
            err_d = !mapped || !addr_ok;
        end
        else if (access)
        begin
            ready_d = 1'b0;
        end
    end

    always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            for (int i = 0; i < NUM_SRC; i++)
            begin
                prio_q[i] <= PRIO_RESET;
            end
            hold_q <= 1'b0;
            vec_q <= 7'h00;
            level_q <= 4'h0;
            req_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            err_q <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < NUM_SRC; i++)
            begin
                prio_q[i] <= prio_d[i];
            end
            hold_q <= hold_d;
            vec_q <= vec_d;
            level_q <= level_d;
            req_q <= req_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q <= err_d;
        end
    end

    // CPU-facing request: highest pending above the CPU level
    logic irq_q;
    logic [6:0] irq_vec_q;
    logic [3:0] irq_lvl_q;
    logic irq_d;
    logic [6:0] irq_vec_d;
    logic [3:0] irq_lvl_d;

    // Level and vector follow the winner every cycle so the CPU reads a settled pair
    always_comb
    begin
        irq_d = best_any && (best_lvl > CPU_LEVEL_IN);
        irq_vec_d = best_vec;
        irq_lvl_d = best_lvl;
    end

    always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            irq_q <= 1'b0;
            irq_vec_q <= 7'h00;
            irq_lvl_q <= 4'h0;
        end
        else
        begin
            irq_q <= irq_d;
            irq_vec_q <= irq_vec_d;
            irq_lvl_q <= irq_lvl_d;
        end
    end

    assign PRDATA_OUT = rdata_q;
    assign PREADY_OUT = ready_q;
    // Error is only loaded with ready, so the flop alone keeps the pair aligned
    assign PSLVERR_OUT = err_q;
    assign IRQ_REQ_OUT = irq_q;
    assign IRQ_VEC_OUT = irq_vec_q;
    assign IRQ_LEVEL_OUT = irq_lvl_q;
endmodule

// >>> src/irq_prio_pkg.sv
// Purpose: Constants for the interrupt priority and vector status block.
// Assumes: APB slave, 32-bit data, registers 16 bits wide in the low half of each word.
// Notes: The printed register numbers are kept as word indices; the byte address is four times the index.
// How it works
// - Each source has a three-bit priority field
// - A zero priority means the source is disabled
// - Priority fields reset to binary 100
// - Unimplemented bits read zero, ignore writes
// - Register 6: timer four, capture unit three
// - Register 7: serial two tx, rx, ext two
// - Register 9: timer three gate only
// - Register 12: sync two collision and event
// - Register 16: serial two and one errors
// - Register 18: voltage detect in bits 2-0
// - Status bit 15 shows a pending request blocked by the CPU level
// - Vector hold bit 13 writable, resets zero
// - Hold set: vector shows highest pending
// - Hold clear: vector shows last acknowledged
// - Bits 11-8 show new CPU level
// - Bits 6-0 hold vector minus eight
// - After reset every source sits at level 4
// - Trap levels 8-15 cannot be masked
package irq_prio_pkg;
    localparam int NUM_SRC = 12;
    localparam logic [2:0] PRIO_RESET = 3'h4;
    // Word indices of the registers
    localparam logic [4:0] IDX_PRIO_6 = 5'h06;
    localparam logic [4:0] IDX_PRIO_7 = 5'h07;
    localparam logic [4:0] IDX_PRIO_9 = 5'h09;
    localparam logic [4:0] IDX_PRIO_12 = 5'h0C;
    localparam logic [4:0] IDX_PRIO_16 = 5'h10;
    localparam logic [4:0] IDX_PRIO_18 = 5'h12;
    localparam logic [4:0] IDX_PRIO_20 = 5'h14;
    localparam logic [4:0] IDX_STATUS = 5'h15;
    // Source numbering, also the bit order of the flag and enable inputs
    localparam int SRC_TIMER_FOUR = 0;
    localparam int SRC_CAPCMP_THREE = 1;
    localparam int SRC_SERIAL_TWO_TX = 2;
    localparam int SRC_SERIAL_TWO_RX = 3;
    localparam int SRC_EXT_IRQ_TWO = 4;
    localparam int SRC_TIMER_THREE_GATE = 5;
    localparam int SRC_SYNC_TWO_COLLISION = 6;
    localparam int SRC_SYNC_TWO_EVENT = 7;
    localparam int SRC_SERIAL_TWO_ERR = 8;
    localparam int SRC_SERIAL_ONE_ERR = 9;
    localparam int SRC_VOLTAGE_DETECT = 10;
    localparam int SRC_LOW_POWER_WAKE = 11;
    // Bit position of the low bit of each field
    localparam int POS_HIGH = 12;
    localparam int POS_MID = 8;
    localparam int POS_LOW = 4;
    localparam int POS_BOTTOM = 0;
    // Status register fields
    localparam int STAT_REQ_BIT = 15;
    localparam int STAT_HOLD_BIT = 13;
    localparam int STAT_LEVEL_POS = 8;
    localparam logic [6:0] VEC_BASE = 7'h08;
    localparam logic [3:0] USER_MAX_LEVEL = 4'h7;
endpackage

// >>> tb/irq_prio_assertions.sv
// Purpose: Port-level checks of the priority and status block.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes: Only relations visible at the ports are checked here.
`timescale 1ns/1ns
module irq_prio_assertions
    import irq_prio_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic [NUM_SRC-1:0] IRQ_FLAG_IN,
    input wire logic [NUM_SRC-1:0] IRQ_ENABLE_IN,
    input wire logic [3:0] CPU_LEVEL_IN,
    input wire logic TRAP_REQ_IN,
    input wire logic [3:0] TRAP_LEVEL_IN,
    input wire logic IRQ_REQ_OUT,
    input wire logic [3:0] IRQ_LEVEL_OUT
);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);
    setup_ready_a: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
        else $error("ready missing after setup");
    ready_single_a: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready held too long");
    ready_access_a: assert property (PREADY_OUT |-> PSEL_IN && PENABLE_IN)
        else $error("ready outside access phase");
    error_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT)
        else $error("error without ready");
    upper_zero_a: assert property (PREADY_OUT |-> PRDATA_OUT[31:16] == 16'h0000)
        else $error("upper read data not zero");
    idle_no_req_a: assert property ((IRQ_FLAG_IN & IRQ_ENABLE_IN) == '0 && !TRAP_REQ_IN |=> !IRQ_REQ_OUT)
        else $error("request with nothing pending");
    req_level_a: assert property (IRQ_REQ_OUT |-> IRQ_LEVEL_OUT > $past(CPU_LEVEL_IN))
        else $error("request not above cpu level");
    trap_unmasked_a: assert property (TRAP_REQ_IN && TRAP_LEVEL_IN > 4'h7 && TRAP_LEVEL_IN > CPU_LEVEL_IN
        |=> IRQ_REQ_OUT && IRQ_LEVEL_OUT == $past(TRAP_LEVEL_IN)) else $error("trap request lost");
endmodule
bind irq_prio_ctrl irq_prio_assertions irq_prio_assertions_inst (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN),
    .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .IRQ_FLAG_IN(IRQ_FLAG_IN), .IRQ_ENABLE_IN(IRQ_ENABLE_IN),
    .CPU_LEVEL_IN(CPU_LEVEL_IN), .TRAP_REQ_IN(TRAP_REQ_IN), .TRAP_LEVEL_IN(TRAP_LEVEL_IN),
    .IRQ_REQ_OUT(IRQ_REQ_OUT), .IRQ_LEVEL_OUT(IRQ_LEVEL_OUT));

// >>> tb/cpu_core_model.sv
// Purpose: Behavioural CPU core that takes interrupt requests.
// Assumes: Request and level come from the block on the same clock.
// Notes: Level rises the cycle after the ack, so the block still sees the winner above it.
`timescale 1ns/1ns
module cpu_core_model
#(
    parameter int ACK_DELAY = 2
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic req_in,
    input wire logic [3:0] level_in,
    input wire logic set_in,
    input wire logic [3:0] set_level_in,
    output logic [3:0] cpu_level_out,
    output logic ack_out
);
    int wait_q;
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wait_q <= 0;
            ack_out <= 1'b0;
            cpu_level_out <= 4'h0;
        end
        else
        begin
            ack_out <= 1'b0;
            if (set_in)
                cpu_level_out <= set_level_in;
            else if (ack_out)
                cpu_level_out <= level_in;
            // Level compare avoids a second ack while the old request drains
            if (req_in && !ack_out && level_in > cpu_level_out)
            begin
                wait_q <= wait_q + 1;
                if (wait_q >= ACK_DELAY)
                    ack_out <= 1'b1;
            end
            else
                wait_q <= 0;
        end
    end
endmodule

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the priority and status block.
// Assumes: APB master in the bench, CPU core model on the far side.
// Notes: Vector offset is eight, so the status vector field equals the source number.
`timescale 1ns/1ns
module testbench;
    import irq_prio_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trap = 1'b0, lvl_set = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq_req, ack, err;
    logic [NUM_SRC-1:0] flags = '0, enables = '0;
    logic [3:0] cpu_level, irq_level, lvl = 4'h0, trap_lvl = 4'h9;
    logic [6:0] irq_vec;
    int miscompares = 0, checks_done = 0;
    logic [7:0] adr [7] = '{8'h18, 8'h1C, 8'h24, 8'h30, 8'h40, 8'h48, 8'h50};
    logic [15:0] msk [7] = '{16'h7070, 16'h7770, 16'h0070, 16'h0770, 16'h0770, 16'h0007, 16'h0007};
    always #20 mclk = ~mclk;
    irq_prio_ctrl #(.VEC_OFFSET(7'h08)) irq_prio_ctrl_inst (.MCLK_IN(mclk), .RST_N_IN(rst_n),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PSTRB_IN(4'hF), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .IRQ_FLAG_IN(flags), .IRQ_ENABLE_IN(enables), .CPU_LEVEL_IN(cpu_level), .TRAP_REQ_IN(trap),
        .TRAP_LEVEL_IN(trap_lvl), .TRAP_VEC_IN(7'h05), .CPU_ACK_IN(ack), .IRQ_REQ_OUT(irq_req),
        .IRQ_VEC_OUT(irq_vec), .IRQ_LEVEL_OUT(irq_level));
    cpu_core_model #(.ACK_DELAY(2)) cpu_core_model_inst (.clk_in(mclk), .rst_n_in(rst_n), .req_in(irq_req),
        .level_in(irq_level), .set_in(lvl_set), .set_level_in(lvl), .cpu_level_out(cpu_level), .ack_out(ack));
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_ack();
        do
        begin
            @(posedge mclk);
        end
        while (ack !== 1'b1);
    endtask
    task automatic test_regs();
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b0, adr[i], 16'h0000);
            chk(rd, {16'h0000, msk[i] & 16'h4444});
            apb(1'b1, adr[i], 16'hFFFF);
            apb(1'b0, adr[i], 16'h0000);
            chk(rd, {16'h0000, msk[i]});
        end
        apb(1'b0, 8'h54, 16'h0000);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h0);
        apb(1'b0, 8'h00, 16'h0000);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b0, 8'h1A, 16'h0000);
        chk({rd[30:0], err}, 32'h1);
        $display("register test done");
    endtask
    task automatic test_irq();
        apb(1'b1, 8'h18, 16'h3000);
        apb(1'b1, 8'h1C, 16'h5000);
        enables <= 12'h00F;
        flags <= 12'h00A;
        repeat (4) @(posedge mclk);
        chk({31'h0, irq_req}, 32'h0);
        flags <= 12'h00F;
        wait_ack();
        chk({irq_level, irq_vec}, {4'h5, 7'h0A});
        repeat (3) @(posedge mclk);
        apb(1'b0, 8'h54, 16'h0000);
        chk(rd, 32'h8502);
        flags <= 12'h001;
        apb(1'b0, 8'h54, 16'h0000);
        chk(rd, 32'h8502);
        apb(1'b1, 8'h54, 16'hBFFF);
        apb(1'b0, 8'h54, 16'h0000);
        chk(rd, 32'hA500);
        apb(1'b1, 8'h54, 16'h0000);
        $display("request test done");
    endtask
    task automatic test_trap();
        lvl <= 4'h7;
        lvl_set <= 1'b1;
        trap_lvl <= 4'h6;
        @(posedge mclk);
        lvl_set <= 1'b0;
        trap <= 1'b1;
        repeat (4) @(posedge mclk);
        chk({31'h0, irq_req}, 32'h0);
        trap_lvl <= 4'h9;
        wait_ack();
        chk({irq_level, irq_vec}, {4'h9, 7'h05});
        trap <= 1'b0;
        flags <= '0;
        repeat (3) @(posedge mclk);
        $display("trap test done");
    endtask
    initial
    begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        test_regs();
        test_irq();
        test_trap();
        stop_test();
    end
    initial
    begin
        repeat (3000) @(posedge mclk);
        miscompares++;
        stop_test();
    end
endmodule
